/* File: verilog/sar_seq_ctrl.sv */
// sequencer, successive-approximation control and register file of the converter
`timescale 1ns/10ps
module sar_seq_ctrl
	import sar_pkg::*;
(
	input  wire logic              clk_i,        // system clock 250 MHz
	input  wire logic              rst_i,        // synchronous reset, high
	input  wire logic              wb_cyc_i,     // bus cycle
	input  wire logic              wb_stb_i,     // bus strobe
	input  wire logic              wb_we_i,      // write enable
	input  wire logic [7:0]        wb_adr_i,     // byte address
	input  wire logic [3:0]        wb_sel_i,     // byte lanes
	input  wire logic [31:0]       wb_dat_i,     // write data
	output logic      [31:0]       wb_dat_o,     // read data
	output logic                   wb_ack_o,     // acknowledge
	input  wire logic              low_power_i,  // deep-sleep or hibernate, async
	input  wire logic              cmp_i,        // comparator: input above trial, async
	output logic                   sample_o,     // track/hold switch closed
	output logic      [2:0]        ch_sel_o,     // input mux channel
	output logic                   diff_o,       // differential mode for this channel
	output logic      [1:0]        ref_sel_o,    // reference selection
	output logic                   temp_bias_o,  // temperature diode bias on
	output logic      [AMUX_W-1:0] amux_sw_o,    // analog mux bus switches
	output logic      [11:0]       dac_code_o,   // trial code to capacitor array
	output logic                   irq_o         // level interrupt
);

	////////////////////////////////////////////////////////////////////////////////
	// synchronisers

	logic lp_meta, lp_sync, cmp_meta, cmp_sync;

	// two stages for the power-mode and comparator levels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lp_meta  <= 1'b0;
			lp_sync  <= 1'b0;
			cmp_meta <= 1'b0;
			cmp_sync <= 1'b0;
		end else begin
			lp_meta  <= low_power_i;
			lp_sync  <= lp_meta;
			cmp_meta <= cmp_i;
			cmp_sync <= cmp_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	logic              enable, cont, bias_en, start_req;
	logic [1:0]        ref_sel;
	logic [7:0]        aper, div_ratio, ch_en, diff_en, irq_mask;
	logic [11:0]       lim_lo, lim_hi;
	logic [AMUX_W-1:0] amux_sw;
	logic [1:0]        irq_stat;
	logic [11:0]       result [NUM_CH];
	logic              bus_req, bus_wr, bus_rd_stat;
	logic [31:0]       wmask;
	logic [31:0]       lim_word, amux_word;
	seq_state_t        state;
	logic [2:0]        cur_ch;
	logic              set_done, set_range;

	assign bus_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_wr      = bus_req & wb_we_i;
	assign bus_rd_stat = bus_req & ~wb_we_i & (wb_adr_i == OFS_STAT);

	// byte-lane mask from select
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
		end
	end

	// merge of written lanes into an old value
	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [31:0] m);
		merge = (old_v & ~m) | (new_v & m);
	endfunction : merge

	// limit and switch words as they stand after a lane-merged write
	assign lim_word  = merge({4'h0, lim_hi, 4'h0, lim_lo}, wb_dat_i, wmask);
	assign amux_word = merge({16'h0000, amux_sw}, wb_dat_i, wmask);

	// software-written configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enable    <= 1'b0;
			cont      <= 1'b0;
			bias_en   <= 1'b0;
			ref_sel   <= REF_SUPPLY;
			aper      <= APER_RST;
			div_ratio <= DIV_RST;
			ch_en     <= 8'h00;
			diff_en   <= 8'h00;
			irq_mask  <= 8'h00;
			lim_lo    <= 12'h000;
			lim_hi    <= LIM_HI_RST;
			amux_sw   <= '0;
		end else if (bus_wr) begin
			case (wb_adr_i)
				OFS_CTRL: begin
					enable  <= wb_sel_i[0] ? wb_dat_i[CTRL_EN] : enable;
					cont    <= wb_sel_i[0] ? wb_dat_i[CTRL_CONT] : cont;
					ref_sel <= wb_sel_i[0] ? wb_dat_i[CTRL_REF_LO +: 2] : ref_sel;      // RULE_03
					bias_en <= wb_sel_i[1] ? wb_dat_i[CTRL_BIAS] : bias_en;             // RULE_11
				end
				OFS_APER: begin
					if (wb_sel_i[0]) begin
						// floor keeps each conversion at 18 converter clocks or more
						aper <= (wb_dat_i[7:0] < APER_MIN) ? APER_MIN : wb_dat_i[7:0]; // RULE_05 RULE_01
					end
				end
				OFS_DIV: begin
					if (wb_sel_i[0]) begin
						div_ratio <= (wb_dat_i[7:0] < DIV_MIN_W) ? DIV_MIN_W : wb_dat_i[7:0]; // RULE_01
					end
				end
				OFS_CHEN:  ch_en    <= wb_sel_i[0] ? wb_dat_i[7:0] : ch_en;           // RULE_10
				OFS_DIFF:  diff_en  <= wb_sel_i[0] ? wb_dat_i[7:0] : diff_en;         // RULE_04
				OFS_MASK:  irq_mask <= wb_sel_i[0] ? wb_dat_i[7:0] : irq_mask;
				OFS_LIMIT: begin
					lim_lo <= lim_word[LIM_LO_LSB +: 12];                                // RULE_08
					lim_hi <= lim_word[LIM_HI_LSB +: 12];                                // RULE_08
				end
				OFS_AMUX:  amux_sw  <= amux_word[AMUX_W-1:0];                           // RULE_12
				default: begin
				end
			endcase
		end
	end

	// start is a one-shot request held until the sequencer is next idle, where it is taken or dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			start_req <= 1'b0;
		end else if (bus_wr && wb_adr_i == OFS_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_START]) begin
			start_req <= 1'b1;
		end else if (state == ST_IDLE) begin
			start_req <= 1'b0;
		end
	end

	// read mux and single-wait acknowledge; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h0000_0000;
			if (bus_req && !wb_we_i) begin
				case (wb_adr_i)
					OFS_CTRL:  wb_dat_o <= {23'h00_0000, bias_en, 2'h0, ref_sel, 1'b0, cont, 1'b0, enable};
					OFS_APER:  wb_dat_o <= {24'h00_0000, aper};
					OFS_DIV:   wb_dat_o <= {24'h00_0000, div_ratio};
					OFS_CHEN:  wb_dat_o <= {24'h00_0000, ch_en};
					OFS_DIFF:  wb_dat_o <= {24'h00_0000, diff_en};
					OFS_MASK:  wb_dat_o <= {24'h00_0000, irq_mask};
					OFS_LIMIT: wb_dat_o <= {4'h0, lim_hi, 4'h0, lim_lo};
					OFS_AMUX:  wb_dat_o <= {16'h0000, amux_sw};
					OFS_STAT:  wb_dat_o <= {17'h0_0000, cur_ch, 3'h0, (state != ST_IDLE),
						6'h00, irq_stat};
					default: begin
						if (wb_adr_i[7:5] == OFS_RES0[7:5] && wb_adr_i[1:0] == 2'h0) begin
							wb_dat_o <= {20'h0_0000, result[wb_adr_i[4:2]]};   // RULE_07
						end
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// converter clock enable

	logic [7:0] div_cnt;
	logic       conv_tick;

	// one pulse every div_ratio system clocks
	always_ff @(posedge clk_i) begin
		if (rst_i || state == ST_IDLE) begin
			div_cnt   <= 8'h01;
			conv_tick <= 1'b0;
		end else if (div_cnt >= div_ratio) begin
			div_cnt   <= 8'h01;
			conv_tick <= 1'b1;                                                       // RULE_01
		end else begin
			div_cnt   <= div_cnt + 8'h01;
			conv_tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer

	// first enabled channel strictly above from; NUM_CH when none remains
	function automatic logic [3:0] next_ch(input logic [7:0] en, input logic [3:0] from);
		next_ch = 4'(NUM_CH);
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (en[i] && 4'(i) > from) begin
				next_ch = 4'(i);
			end
		end
	endfunction : next_ch

	logic [7:0]  aper_cnt;
	logic [3:0]  bit_idx;
	logic [11:0] trial;
	logic [3:0]  first_ch, follow_ch;
	logic        go;

	// channel 0 cannot be named by the strictly-above search, so test it first
	assign first_ch  = ch_en[0] ? 4'h0 : next_ch(ch_en, 4'h0);
	assign follow_ch = next_ch(ch_en, {1'b0, cur_ch});
	assign go        = enable && !lp_sync && (start_req || cont) && ch_en != 8'h00;

	// state walk: sample, bit trials, store, then straight to the next channel
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state    <= ST_IDLE;
			cur_ch   <= 3'h0;
			aper_cnt <= 8'h00;
			bit_idx  <= 4'h0;
			trial    <= 12'h000;
			set_done <= 1'b0;
		end else begin
			set_done <= 1'b0;
			if (lp_sync || !enable) begin
				state <= ST_IDLE;                                                     // RULE_09
			end else begin
				case (state)
					ST_IDLE: begin
						if (go) begin
							state    <= ST_SAMPLE;
							cur_ch   <= first_ch[2:0];
							aper_cnt <= aper;
						end
					end
					ST_SAMPLE: begin
						if (conv_tick) begin
							if (aper_cnt == 8'h01) begin
								state   <= ST_CONV;
								bit_idx <= 4'(RES_BITS - 1);
								trial   <= 12'h800;
							end else begin
								aper_cnt <= aper_cnt - 8'h01;                          // RULE_05
							end
						end
					end
					ST_CONV: begin
						if (conv_tick) begin
							// keep the trial bit when the input stands above it
							if (!cmp_sync) begin
								trial[bit_idx] <= 1'b0;                                 // RULE_02
							end
							if (bit_idx == 4'h0) begin
								state <= ST_STORE;
							end else begin
								trial[bit_idx - 4'h1] <= 1'b1;
								bit_idx <= bit_idx - 4'h1;
							end
						end
					end
					ST_STORE: begin
						if (conv_tick) begin
							// no idle gap: next channel sampled on the same tick
							if (follow_ch != 4'(NUM_CH)) begin
								state    <= ST_SAMPLE;                                 // RULE_06
								cur_ch   <= follow_ch[2:0];
								aper_cnt <= aper;
							end else begin
								set_done <= 1'b1;                                      // RULE_07
								if (cont && ch_en != 8'h00) begin
									state    <= ST_SAMPLE;
									cur_ch   <= first_ch[2:0];
									aper_cnt <= aper;
								end else begin
									state <= ST_IDLE;
								end
							end
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// per-channel result buffers and window check at the store tick
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			set_range <= 1'b0;
			for (int i = 0; i < NUM_CH; i++) begin
				result[i] <= 12'h000;
			end
		end else begin
			set_range <= 1'b0;
			if (state == ST_STORE && conv_tick && !lp_sync && enable) begin
				result[cur_ch] <= trial;                                                 // RULE_07
				set_range      <= (trial < lim_lo) || (trial > lim_hi);                  // RULE_08
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupts

	// sticky flags; a set in the clearing read cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= 2'b00;
			irq_o    <= 1'b0;
		end else begin
			irq_stat[ST_DONE]  <= set_done  | (irq_stat[ST_DONE]  & ~bus_rd_stat);   // RULE_13
			irq_stat[ST_RANGE] <= set_range | (irq_stat[ST_RANGE] & ~bus_rd_stat);   // RULE_13
			irq_o <= |(irq_stat & irq_mask[1:0]);                                      // RULE_13
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// analog front-end controls

	// registered drive of mux, reference, bias and trial code
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sample_o    <= 1'b0;
			ch_sel_o    <= 3'h0;
			diff_o      <= 1'b0;
			ref_sel_o   <= REF_SUPPLY;
			temp_bias_o <= 1'b0;
			amux_sw_o   <= '0;
			dac_code_o  <= 12'h000;
		end else begin
			sample_o    <= (state == ST_SAMPLE);
			ch_sel_o    <= cur_ch;                                                       // RULE_10
			diff_o      <= diff_en[cur_ch];                                              // RULE_04
			ref_sel_o   <= ref_sel;                                                      // RULE_03
			temp_bias_o <= bias_en;                                                      // RULE_11
			amux_sw_o   <= amux_sw;                                                      // RULE_12
			dac_code_o  <= trial;
		end
	end

endmodule : sar_seq_ctrl

/* File: verilog/sar_pkg.sv */
// constants, register map and types for the converter sequencer control
//
// Functional notes
// [RULE_01] converter clock at most 18 MHz; a conversion lasts at least 18 converter clocks
// [RULE_02] every conversion yields a 12-bit result
// [RULE_03] reference chosen from supply, half supply, internal trimmed, or external pin
// [RULE_04] each channel set single-ended or differential independently within one scan
// [RULE_05] sample-and-hold aperture length programmable in converter clocks
// [RULE_06] sequencer steps enabled channels back to back with no idle cycles
// [RULE_07] one result buffer per channel; scan interrupt only after all converted
// [RULE_08] results checked against low/high limits; range interrupt raised at once
// [RULE_09] no conversions while system is in deep-sleep or hibernate
// [RULE_10] temperature sensor is a sequencer channel converted like any other
// [RULE_11] control bit switches the temperature diode bias current on or off
// [RULE_12] software switches route converter input over the analog mux bus to pins
// [RULE_13] interrupt flags stay set until cleared; output is OR of unmasked flags
package sar_pkg;

	localparam int          SYS_CLK_HZ    = 250_000_000;
	localparam int          CONV_CLK_MAX_HZ = 18_000_000;
	// least divide ratio keeping the converter clock at or below its ceiling
	localparam int          DIV_MIN       = (SYS_CLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ;
	localparam logic [7:0]  DIV_MIN_W     = 8'(DIV_MIN);
	localparam int          CONV_CLKS_MIN = 18;
	localparam int          RES_BITS      = 12;
	// aperture floor so sampling plus bit trials plus store reach the minimum
	localparam logic [7:0]  APER_MIN      = 8'(CONV_CLKS_MIN - RES_BITS - 1);
	localparam int          NUM_CH        = 8;
	localparam logic [2:0]  TEMP_CH       = 3'h7;
	localparam int          AMUX_W        = 16;

	// register byte offsets
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_APER      = 8'h04;
	localparam logic [7:0]  OFS_CHEN      = 8'h08;
	localparam logic [7:0]  OFS_DIFF      = 8'h0c;
	localparam logic [7:0]  OFS_LIMIT     = 8'h10;
	localparam logic [7:0]  OFS_STAT      = 8'h14;
	localparam logic [7:0]  OFS_MASK      = 8'h18;
	localparam logic [7:0]  OFS_AMUX      = 8'h1c;
	localparam logic [7:0]  OFS_DIV       = 8'h20;
	localparam logic [7:0]  OFS_RES0      = 8'h40;

	// control register fields
	localparam int          CTRL_EN       = 0;
	localparam int          CTRL_START    = 1;
	localparam int          CTRL_CONT     = 2;
	localparam int          CTRL_REF_LO   = 4;
	localparam int          CTRL_BIAS     = 8;
	// limit register fields
	localparam int          LIM_LO_LSB    = 0;
	localparam int          LIM_HI_LSB    = 16;
	// status fields
	localparam int          ST_DONE       = 0;
	localparam int          ST_RANGE      = 1;
	localparam int          ST_BUSY       = 8;
	localparam int          ST_CH_LSB     = 12;

	localparam logic [7:0]  APER_RST      = 8'h06;
	localparam logic [7:0]  DIV_RST       = 8'h0e;
	localparam logic [11:0] LIM_HI_RST    = 12'hfff;

	typedef enum logic [1:0] {
		REF_SUPPLY = 2'h0,
		REF_HALF   = 2'h1,
		REF_TRIM   = 2'h2,
		REF_EXT    = 2'h3
	} ref_sel_t;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_SAMPLE = 4'b0010,
		ST_CONV   = 4'b0100,
		ST_STORE  = 4'b1000
	} seq_state_t;

endpackage : sar_pkg

/* File: sim/sar_seq_ctrl_props.sv */
// port-level checker of the converter sequencer control
`timescale 1ns/10ps
module sar_seq_ctrl_props
	import sar_pkg::*;
(
	input wire logic              clk_i,       // clock
	input wire logic              rst_i,       // reset
	input wire logic              wb_cyc_i,    // cycle
	input wire logic              wb_stb_i,    // strobe
	input wire logic              wb_we_i,     // write
	input wire logic [7:0]        wb_adr_i,    // address
	input wire logic [3:0]        wb_sel_i,    // lanes
	input wire logic [31:0]       wb_dat_i,    // write data
	input wire logic              wb_ack_o,    // acknowledge
	input wire logic              low_power_i, // low power
	input wire logic              sample_o,    // tracking
	input wire logic [2:0]        ch_sel_o,    // channel
	input wire logic              diff_o,      // differential
	input wire logic [1:0]        ref_sel_o,   // reference
	input wire logic              temp_bias_o, // diode bias
	input wire logic [AMUX_W-1:0] amux_sw_o,   // mux bus switches
	input wire logic              irq_o        // interrupt
);
	localparam int SAMP_MIN = 70;
	localparam int PER_MIN  = 252;
	logic       take;
	logic       clr_ev;
	logic [7:0] chen;
	logic [7:0] diff;
	logic [8:0] hi_cnt;
	logic [8:0] per_cnt;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// taken requests and the ones that may drop the interrupt
	assign take   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign clr_ev = take & ((~wb_we_i & wb_adr_i == OFS_STAT) | (wb_we_i & wb_adr_i == OFS_MASK));
	// shadow of channel enable and differential settings
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chen <= 8'h00;
			diff <= 8'h00;
		end else if (take && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == OFS_CHEN) chen <= wb_dat_i[7:0];
			if (wb_adr_i == OFS_DIFF) diff <= wb_dat_i[7:0];
		end
	end
	// length of tracking and distance between channel starts
	always_ff @(posedge clk_i) begin
		if (rst_i || !sample_o) hi_cnt <= 9'h000;
		else if (hi_cnt != 9'h1ff) hi_cnt <= hi_cnt + 9'h001;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) per_cnt <= 9'h1ff;
		else if ($rose(sample_o)) per_cnt <= 9'h001;
		else if (per_cnt != 9'h1ff) per_cnt <= per_cnt + 9'h001;
	end
	////////////////////////////////////////////////////////////////////////////////
	sequence s_wr(logic [7:0] a);
		take && wb_we_i && wb_adr_i == a;
	endsequence
	sequence s_lp;
		// two sync stages, the state update and the registered output
		low_power_i [*5];
	endsequence
	property p_samp_len; $fell(sample_o) && !low_power_i |-> hi_cnt >= SAMP_MIN; endproperty
	property p_conv_per; $rose(sample_o) |-> per_cnt >= PER_MIN; endproperty
	property p_lp; s_lp |-> !sample_o; endproperty
	property p_irq_hold; irq_o && !clr_ev && !$past(clr_ev) |=> irq_o; endproperty
	property p_bias;
		s_wr(OFS_CTRL) ##0 wb_sel_i[1] |-> ##3 temp_bias_o == $past(wb_dat_i[CTRL_BIAS], 3);
	endproperty
	property p_ref;
		s_wr(OFS_CTRL) ##0 wb_sel_i[0] |-> ##3 ref_sel_o == $past(wb_dat_i[5:4], 3);
	endproperty
	property p_amux;
		s_wr(OFS_AMUX) ##0 wb_sel_i == 4'hf |-> ##3 amux_sw_o == $past(wb_dat_i[15:0], 3);
	endproperty
	property p_chen; sample_o |-> chen[ch_sel_o]; endproperty
	property p_diff; sample_o |-> diff_o == diff[ch_sel_o]; endproperty
	a_samp_len: assert property (p_samp_len)
		else $error("tracking phase too short");
	a_conv_per: assert property (p_conv_per)
		else $error("conversion shorter than minimum");
	a_lp: assert property (p_lp)
		else $error("tracking in low power");
	a_irq_hold: assert property (p_irq_hold)
		else $error("interrupt dropped without clear");
	a_bias: assert property (p_bias)
		else $error("diode bias not following control");
	a_ref: assert property (p_ref)
		else $error("reference select not following control");
	a_amux: assert property (p_amux)
		else $error("mux bus switches not following register");
	a_chen: assert property (p_chen)
		else $error("disabled channel sampled");
	a_diff: assert property (p_diff)
		else $error("channel mode mismatch");
endmodule : sar_seq_ctrl_props
bind sar_seq_ctrl sar_seq_ctrl_props PROPS (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .low_power_i, .sample_o, .ch_sel_o, .diff_o,
	.ref_sel_o, .temp_bias_o, .amux_sw_o, .irq_o);

/* File: sim/sar_analog_model.sv */
// behavioural analog inputs and comparator facing the converter
`timescale 1ns/10ps
module sar_analog_model (
	input  wire logic        clk_i,     // system clock
	input  wire logic        sample_i,  // tracking phase
	input  wire logic [2:0]  ch_i,      // selected channel
	input  wire logic [11:0] code_i,    // trial code
	input  wire logic [11:0] vin_i [8], // channel levels
	output logic             cmp_o      // comparator decision
);
	logic tog = 1'b0;
	// decision is meaningless while tracking, so keep it moving
	always_ff @(posedge clk_i) begin
		tog <= ~tog;
	end
	// held level at or above the trial keeps the bit
	assign cmp_o = sample_i ? tog : (vin_i[ch_i] >= code_i);
endmodule : sar_analog_model

/* File: sim/tb.sv */
// self-checking bench of the converter sequencer control
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("Error %s exp %0h got %0h", n, e, g); end end
module tb;
	import sar_pkg::*;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, low_power_i, cmp_i;
	logic        sample_o, diff_o, temp_bias_o, irq_o;
	logic [7:0]  wb_adr_i, en;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q, ctl, am;
	logic [2:0]  ch_sel_o;
	logic [1:0]  ref_sel_o;
	logic [15:0] amux_sw_o;
	logic [11:0] dac_code_o;
	logic [11:0] vin [8];
	int          fails, checks_done, seed, r, i, chq[$];
	sar_seq_ctrl DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .low_power_i, .cmp_i, .sample_o, .ch_sel_o, .diff_o,
		.ref_sel_o, .temp_bias_o, .amux_sw_o, .dac_code_o, .irq_o);
	sar_analog_model ANA (.clk_i, .sample_i(sample_o), .ch_i(ch_sel_o), .code_i(dac_code_o),
		.vin_i(vin), .cmp_o(cmp_i));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic end_sim;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	// one classic bus cycle, read data left in q
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_sel_i <= 4'hf;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			end_sim();
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq_o !== 1'b1 && n < 4000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 4000) begin
			fails++;
			end_sim();
		end
	endtask : wait_irq
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, low_power_i, wb_adr_i, wb_dat_i} <= '0;
		{fails, checks_done} = '0;
		wb_sel_i <= 4'hf;
		seed = 96;
		rst_i <= 1'b1;
		foreach (vin[i]) vin[i] = 12'h000;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		// reset values, unmapped place and floors
		wb(1'b0, OFS_APER, 32'h0000_0000);
		`CHK("aper reset", 32'(APER_RST), q)
		wb(1'b0, OFS_LIMIT, 32'h0000_0000);
		`CHK("limit reset", {4'h0, LIM_HI_RST, 16'h0000}, q)
		wb(1'b0, 8'h24, 32'h0000_0000);
		`CHK("unmapped", 32'h0000_0000, q)
		wb(1'b1, OFS_APER, 32'h0000_0002);
		wb(1'b0, OFS_APER, 32'h0000_0000);
		`CHK("aper floor", 32'(APER_MIN), q)
		wb(1'b1, OFS_DIV, 32'h0000_0003);
		wb(1'b0, OFS_DIV, 32'h0000_0000);
		`CHK("div floor", 32'(DIV_MIN), q)
		wb(1'b1, OFS_LIMIT, 32'h0e00_0100);
		for (r = 0; r < 4; r++) begin
			// later rounds leave channel 0 out so the scan opens higher up
			en = (8'($random(seed)) | 8'h02 | 8'(1 << TEMP_CH)) & ~{7'h00, r[1]};
			chq.delete();
			for (i = 0; i < NUM_CH; i++) if (en[i]) chq.push_back(i);
			foreach (vin[i]) vin[i] = 12'h100 + 12'($unsigned($random(seed)) % 3328);
			// lowest enabled channel lies outside the window
			vin[chq[0]] = r[0] ? 12'hf00 : 12'h050;
			am = $random(seed);
			ctl = 32'h0000_0003 | (r << CTRL_REF_LO) | (r[0] << CTRL_BIAS);
			wb(1'b1, OFS_AMUX, am);
			wb(1'b1, OFS_DIFF, $random(seed));
			wb(1'b1, OFS_CHEN, {24'h00_0000, en});
			wb(1'b1, OFS_MASK, 32'h0000_0002);
			wb(1'b1, OFS_CTRL, ctl);
			`CHK("amux", am[15:0], amux_sw_o)
			wait_irq();
			wb(1'b0, OFS_STAT, 32'h0000_0000);
			`CHK("range early", 3'b110, {q[ST_BUSY], q[1:0]})
			`CHK("ref", 2'(r), ref_sel_o)
			`CHK("bias", r[0], temp_bias_o)
			wb(1'b1, OFS_MASK, 32'h0000_0003);
			wait_irq();
			wb(1'b0, OFS_STAT, 32'h0000_0000);
			`CHK("scan done", 3'b001, {q[ST_BUSY], q[1:0]})
			@(posedge clk_i);
			`CHK("irq cleared", 1'b0, irq_o)
			foreach (chq[i]) begin
				wb(1'b0, OFS_RES0 + 8'(4 * chq[i]), 32'h0000_0000);
				`CHK("result", {20'h0, vin[chq[i]]}, q)
			end
		end
		// continuous scan restarts by itself, then low power aborts it
		wb(1'b1, OFS_MASK, 32'h0000_0001);
		wb(1'b1, OFS_CTRL, 32'h0000_0005);
		wait_irq();
		wb(1'b0, OFS_STAT, 32'h0000_0000);
		`CHK("cont rescan", 2'b11, {q[ST_BUSY], q[ST_DONE]})
		repeat (100) @(posedge clk_i);
		low_power_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		`CHK("lp tracking", 1'b0, sample_o)
		repeat (3000) @(posedge clk_i);
		`CHK("lp no done", 1'b0, irq_o)
		wb(1'b0, OFS_STAT, 32'h0000_0000);
		`CHK("lp idle", 1'b0, q[ST_BUSY])
		low_power_i <= 1'b0;
		end_sim();
	end
endmodule : tb
